// file: hw/cts_touch_counter.v
// capacitive touch sense front end with two oscillator-clocked timers
//
// Overview of operation
// - sixteen sense inputs, four-bit channel select
// - enabled module with range not 00 drives oscillator on selected pin
// - read-only oscillator current direction status bit
// - two-bit field gives three current settings
// - oscillator clocks first or gated timer
// - ext select set, clock select clear: first timer
// - gated timer clock field 11 selects oscillator
// - gated timer off, free, or gate controlled
// - enable bit clear shuts the module off
// - range 00 off; 01/10/11 low/medium/high
// - disabled module connects no sense channel
// - status one sourcing, zero sinking
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "cts_map.vh"
module cts_touch_counter (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [31:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    input  wire        i_osc_wave,
    input  wire        i_osc_sourcing,
    input  wire        i_gate,
    output reg  [15:0] o_sense_pin_connect,
    output reg  [1:0]  o_osc_current_range,
    output reg         o_osc_enable
);
    reg                    sense_module_enable_ff;
    reg  [1:0]             osc_current_range_ff;
    reg                    first_timer_ext_source_sel_ff;
    reg  [`CTS_CH_W-1:0]   sense_channel_select_ff;
    reg  [1:0]             gated_timer_clock_sel_ff;
    reg                    gated_timer_gate_enable_ff;
    reg                    gate_toggle_mode_ff;
    reg                    gated_timer_on_ff;
    reg                    first_timer_clock_sel_ff;
    reg  [7:0]             first_cnt_ff;
    reg  [15:0]            gated_cnt_ff;
    reg                    toggle_ff;
    reg  [31:0]            nxt_prdata;
    reg                    nxt_pslverr;
    wire                   osc_lvl;
    wire                   osc_rise;
    wire                   dir_lvl;
    wire                   gate_lvl;
    wire                   gate_rise;
    wire                   osc_run;
    wire                   ft_pulse;
    wire                   gt_pulse;
    wire                   gt_gate_open;
    wire                   gt_count;
    wire                   acc;
    wire                   wr;
    wire [`CTS_ADDR_W-1:0] addr;

    assign addr = i_paddr[`CTS_ADDR_W-1:0];
    assign acc  = i_psel & i_penable & ~o_pready;
    assign wr   = acc & i_pwrite & ~nxt_pslverr;

    cts_edge_sync u_osc_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_osc_wave),
        .o_level (osc_lvl),
        .o_rise  (osc_rise)
    );
    cts_edge_sync u_dir_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_osc_sourcing),
        .o_level (dir_lvl),
        .o_rise  ()
    );
    cts_edge_sync u_gate_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_gate),
        .o_level (gate_lvl),
        .o_rise  (gate_rise)
    );

    // oscillator live only when enabled and range not off
    assign osc_run  = sense_module_enable_ff & (osc_current_range_ff != `CTS_RNG_OFF);
    // one count per synchronised rising edge
    assign ft_pulse = osc_run & osc_rise & first_timer_ext_source_sel_ff
                      & ~first_timer_clock_sel_ff;
    assign gt_pulse = osc_run & osc_rise
                      & (gated_timer_clock_sel_ff == `CTS_GT_CS_OSC);
    assign gt_gate_open = gate_toggle_mode_ff ? toggle_ff : gate_lvl;
    assign gt_count = gated_timer_on_ff & (~gated_timer_gate_enable_ff | gt_gate_open)
                      & gt_pulse;

    // apb read mux and error decode
    always @* begin
        nxt_prdata  = `CTS_ZERO32;
        nxt_pslverr = 1'b0;
        case (addr)
            `CTS_ADDR_MAIN: begin
                nxt_prdata[`CTS_MAIN_EN]                      = sense_module_enable_ff;
                nxt_prdata[`CTS_MAIN_RNG_HI:`CTS_MAIN_RNG_LO] = osc_current_range_ff;
                nxt_prdata[`CTS_MAIN_DIR]  = dir_lvl;
                nxt_prdata[`CTS_MAIN_XSEL] = first_timer_ext_source_sel_ff;
            end
            `CTS_ADDR_CHAN: begin
                nxt_prdata[`CTS_CH_W-1:0] = sense_channel_select_ff;
            end
            `CTS_ADDR_GTCTL: begin
                nxt_prdata[`CTS_GT_CS_HI:`CTS_GT_CS_LO] = gated_timer_clock_sel_ff;
                nxt_prdata[`CTS_GT_GE] = gated_timer_gate_enable_ff;
                nxt_prdata[`CTS_GT_TM] = gate_toggle_mode_ff;
                nxt_prdata[`CTS_GT_ON] = gated_timer_on_ff;
            end
            `CTS_ADDR_FTCTL: begin
                nxt_prdata[`CTS_FT_CS] = first_timer_clock_sel_ff;
            end
            `CTS_ADDR_FTCNT: begin
                nxt_prdata[`CTS_FT_W-1:0] = first_cnt_ff;
            end
            `CTS_ADDR_GTCNT: begin
                nxt_prdata[`CTS_GT_W-1:0] = gated_cnt_ff;
            end
            default: begin
                nxt_pslverr = 1'b1;
            end
        endcase
        if (|i_paddr[31:`CTS_ADDR_W]) begin
            nxt_pslverr = 1'b1;
        end
    end

    // apb slave: one wait state, answer in second access cycle
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= `CTS_ZERO32;
        end else begin
            o_pready  <= acc;
            o_pslverr <= acc & nxt_pslverr;
            o_prdata  <= (acc & ~i_pwrite & ~nxt_pslverr) ? nxt_prdata : `CTS_ZERO32;
        end
    end

    // control registers
    always @(posedge i_clk) begin
        if (i_rst) begin
            sense_module_enable_ff        <= 1'b0;
            osc_current_range_ff          <= `CTS_RNG_OFF;
            first_timer_ext_source_sel_ff <= 1'b0;
            sense_channel_select_ff       <= {`CTS_CH_W{1'b0}};
            gated_timer_clock_sel_ff      <= 2'h0;
            gated_timer_gate_enable_ff    <= 1'b0;
            gate_toggle_mode_ff           <= 1'b0;
            gated_timer_on_ff             <= 1'b0;
            first_timer_clock_sel_ff      <= 1'b1;
        end else if (wr) begin
            case (addr)
                `CTS_ADDR_MAIN: begin
                    sense_module_enable_ff        <= i_pwdata[`CTS_MAIN_EN];
                    osc_current_range_ff          <= i_pwdata[`CTS_MAIN_RNG_HI:`CTS_MAIN_RNG_LO];
                    first_timer_ext_source_sel_ff <= i_pwdata[`CTS_MAIN_XSEL];
                end
                `CTS_ADDR_CHAN: begin
                    sense_channel_select_ff <= i_pwdata[`CTS_CH_W-1:0];
                end
                `CTS_ADDR_GTCTL: begin
                    gated_timer_clock_sel_ff   <= i_pwdata[`CTS_GT_CS_HI:`CTS_GT_CS_LO];
                    gated_timer_gate_enable_ff <= i_pwdata[`CTS_GT_GE];
                    gate_toggle_mode_ff        <= i_pwdata[`CTS_GT_TM];
                    gated_timer_on_ff          <= i_pwdata[`CTS_GT_ON];
                end
                `CTS_ADDR_FTCTL: begin
                    first_timer_clock_sel_ff <= i_pwdata[`CTS_FT_CS];
                end
                default: begin
                end
            endcase
        end
    end

    // counters: a write clears or loads, a write wins over a count
    always @(posedge i_clk) begin
        if (i_rst) begin
            first_cnt_ff <= `CTS_ZERO8;
            gated_cnt_ff <= `CTS_ZERO16;
            toggle_ff    <= 1'b0;
        end else begin
            if (wr && addr == `CTS_ADDR_FTCNT) begin
                first_cnt_ff <= i_pwdata[`CTS_FT_W-1:0];
            end else if (ft_pulse) begin
                first_cnt_ff <= first_cnt_ff + `CTS_ONE8;
            end
            if (wr && addr == `CTS_ADDR_GTCNT) begin
                gated_cnt_ff <= i_pwdata[`CTS_GT_W-1:0];
            end else if (gt_count) begin
                gated_cnt_ff <= gated_cnt_ff + `CTS_ONE16;
            end
            // toggle flop cleared while toggle mode is off
            if (!gate_toggle_mode_ff) begin
                toggle_ff <= 1'b0;
            end else if (gate_rise) begin
                toggle_ff <= ~toggle_ff;
            end
        end
    end

    // analog mux and oscillator drive
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_sense_pin_connect <= `CTS_ZERO16;
            o_osc_current_range <= `CTS_RNG_OFF;
            o_osc_enable        <= 1'b0;
        end else begin
            o_sense_pin_connect <= sense_module_enable_ff
                ? (`CTS_ONE16 << sense_channel_select_ff) : `CTS_ZERO16;
            o_osc_current_range <= sense_module_enable_ff
                ? osc_current_range_ff : `CTS_RNG_OFF;
            o_osc_enable        <= osc_run;
        end
    end
endmodule // cts_touch_counter

// file: hw/cts_map.vh
// register offsets, field positions and encodings of the touch sense counter
`ifndef CTS_MAP_VH
`define CTS_MAP_VH
`define CTS_ADDR_MAIN      12'h000
`define CTS_ADDR_CHAN      12'h004
`define CTS_ADDR_GTCTL     12'h008
`define CTS_ADDR_FTCTL     12'h00C
`define CTS_ADDR_FTCNT     12'h010
`define CTS_ADDR_GTCNT     12'h014
`define CTS_ADDR_W         12
`define CTS_MAIN_EN        7
`define CTS_MAIN_RNG_HI    3
`define CTS_MAIN_RNG_LO    2
`define CTS_MAIN_DIR       1
`define CTS_MAIN_XSEL      0
`define CTS_GT_CS_HI       7
`define CTS_GT_CS_LO       6
`define CTS_GT_GE          5
`define CTS_GT_TM          4
`define CTS_GT_ON          0
`define CTS_FT_CS          0
`define CTS_RNG_OFF        2'h0
`define CTS_GT_CS_OSC      2'h3
`define CTS_CH_W           4
`define CTS_FT_W           8
`define CTS_GT_W           16
`define CTS_NCH            16
`define CTS_ZERO32         32'h00000000
`define CTS_ZERO8          8'h00
`define CTS_ZERO16         16'h0000
`define CTS_ONE8           8'h01
`define CTS_ONE16          16'h0001
`endif

// file: hw/cts_edge_sync.v
// two-flop synchroniser with rising edge pulse
`timescale 1ns/1ns
module cts_edge_sync (
    input  wire i_clk,
    input  wire i_rst,
    input  wire i_async,
    output wire o_level,
    output wire o_rise
);
    reg meta_ff;
    reg sync_ff;
    reg prev_ff;
    always @(posedge i_clk) begin
        if (i_rst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end
    assign o_level = sync_ff;
    assign o_rise  = sync_ff & ~prev_ff;
endmodule // cts_edge_sync

// file: verif/cts_touch_counter_properties.sv
// port assertions for the touch sense counter
`timescale 1ns/1ns
module cts_props (
    input wire        i_clk,
    input wire        i_rst,
    input wire        i_psel,
    input wire        i_penable,
    input wire [31:0] i_paddr,
    input wire [31:0] o_prdata,
    input wire        o_pready,
    input wire        o_pslverr,
    input wire [15:0] o_sense_pin_connect,
    input wire [1:0]  o_osc_current_range,
    input wire        o_osc_enable
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire take = i_psel && i_penable && !o_pready;
    AST_ANSWER: assert property (take |=> o_pready ##1 !o_pready)
        else $error("answer not one cycle");
    AST_UNMAPPED: assert property (take && i_paddr[31:12] != 20'h0 |=> o_pslverr)
        else $error("no error on bad address");
    AST_ERR_READY: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    AST_IDLE_DATA: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside answer");
    AST_ONE_PIN: assert property ($onehot0(o_sense_pin_connect))
        else $error("several pins connected");
    AST_OSC_PIN: assert property (o_osc_enable |-> $onehot(o_sense_pin_connect))
        else $error("oscillator without pin");
    AST_RANGE_OFF: assert property (o_osc_enable == (o_osc_current_range != 2'h0))
        else $error("enable and range disagree");
    AST_RANGE_PIN: assert property (o_sense_pin_connect == 16'h0 |-> o_osc_current_range == 2'h0)
        else $error("range with no pin");
endmodule // cts_props
bind cts_touch_counter cts_props cts_props_inst (.i_clk, .i_rst, .i_psel, .i_penable, .i_paddr,
    .o_prdata, .o_pready, .o_pslverr, .o_sense_pin_connect, .o_osc_current_range, .o_osc_enable);

// file: verif/cts_pad_model.sv
// pad oscillator model: bursts of square-wave cycles on the sense pin
`timescale 1ns/1ns
module cts_pad_model (
    input  wire       i_clk,
    input  wire       i_start,
    input  wire [7:0] i_cycles,
    input  wire       i_run,
    output logic      o_wave = 1'b0,
    output wire       o_busy
);
    logic [7:0] left_ff = 8'h00;
    logic [1:0] ph_ff = 2'h0;
    assign o_busy = left_ff != 8'h00;
    // runs only while the pin is an undriven analog input
    always @(posedge i_clk) begin
        if (i_start) begin
            left_ff <= i_cycles;
        end else if (o_busy && i_run) begin
            ph_ff <= ph_ff + 2'h1;
            o_wave <= o_wave ^ (ph_ff == 2'h3);
            if (ph_ff == 2'h3 && o_wave) left_ff <= left_ff - 8'h01;
        end
    end
endmodule // cts_pad_model

// file: verif/cts_touch_counter_bench.sv
// self-checking bench for the touch sense counter
`timescale 1ns/1ns
`include "cts_map.vh"
module cts_touch_counter_bench;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, src = 0, gate = 0;
    logic        start = 0, force_run = 0;
    logic [7:0]  cyc = 8'h00;
    logic [31:0] pa = 32'h0, pwd = 32'h0;
    wire  [31:0] prd;
    wire  [15:0] pins;
    wire  [1:0]  rng;
    wire         rdy, err, wave, busy, oen;
    int          failures = 0, compares = 0;
    logic        err_seen = 1'b0;
    always #5 clk = ~clk;
    cts_touch_counter cts_touch_counter_inst (.i_clk(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
        .o_pready(rdy), .o_pslverr(err), .i_osc_wave(wave), .i_osc_sourcing(src), .i_gate(gate),
        .o_sense_pin_connect(pins), .o_osc_current_range(rng), .o_osc_enable(oen));
    cts_pad_model cts_pad_model_inst (.i_clk(clk), .i_start(start), .i_cycles(cyc),
        .i_run(oen | force_run), .o_wave(wave), .o_busy(busy));
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            failures++;
            $display("unexpected %0t got %h want %h", $time, got, want);
        end
    endtask
    // one apb transfer; on a read d is the expected data
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        if (!w) chk(prd, d);
        err_seen = err;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    // n oscillator cycles, sync latency settles, then read a count
    task automatic burst(input logic [7:0] n, input logic [31:0] a, input logic [31:0] x);
        cyc <= n;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        while (busy) @(posedge clk);
        repeat (6) @(posedge clk);
        acc(1'b0, a, x);
    endtask
    task automatic results;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #200000 failures++;
        results;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) acc(1'b0, i * 4, i == 3);
        acc(1'b1, 32'h1000, 32'hFF);
        chk(err_seen, 1'b1);
        acc(1'b0, `CTS_ADDR_MAIN, 32'h0);
        chk(err_seen, 1'b0);
        acc(1'b0, 32'h18, 32'h0);
        chk(err_seen, 1'b1);
        acc(1'b1, `CTS_ADDR_MAIN, 32'h84);
        for (int c = 0; c < 16; c++) begin
            acc(1'b1, `CTS_ADDR_CHAN, c);
            chk(pins, 32'h1 << c);
        end
        acc(1'b0, `CTS_ADDR_CHAN, 32'hF);
        for (int r = 0; r < 4; r++) begin
            src <= r[0];
            acc(1'b1, `CTS_ADDR_MAIN, 32'h82 | (r << 2));
            chk({oen, rng}, {r != 0, 2'(r)});
            acc(1'b0, `CTS_ADDR_MAIN, 32'h80 | (r << 2) | (r[0] << 1));
        end
        acc(1'b1, `CTS_ADDR_MAIN, 32'h0C);
        chk({pins, rng, oen}, 32'h0);
        acc(1'b1, `CTS_ADDR_MAIN, 32'h85);
        burst(3, `CTS_ADDR_FTCNT, 32'h0);
        acc(1'b1, `CTS_ADDR_FTCTL, 32'h0);
        burst(5, `CTS_ADDR_FTCNT, 32'h5);
        acc(1'b1, `CTS_ADDR_GTCTL, 32'hC1);
        acc(1'b0, `CTS_ADDR_GTCTL, 32'hC1);
        burst(3, `CTS_ADDR_GTCNT, 32'h3);
        acc(1'b1, `CTS_ADDR_GTCTL, 32'hE1);
        burst(2, `CTS_ADDR_GTCNT, 32'h3);
        gate <= 1'b1;
        burst(2, `CTS_ADDR_GTCNT, 32'h5);
        acc(1'b1, `CTS_ADDR_GTCTL, 32'hC0);
        burst(2, `CTS_ADDR_GTCNT, 32'h5);
        acc(1'b1, `CTS_ADDR_GTCNT, 32'h0);
        acc(1'b0, `CTS_ADDR_GTCNT, 32'h0);
        // toggle mode: gate rising edges open and close the window
        acc(1'b1, `CTS_ADDR_GTCTL, 32'hF1);
        burst(2, `CTS_ADDR_GTCNT, 32'h0);
        gate <= 1'b0;
        repeat (4) @(posedge clk);
        gate <= 1'b1;
        burst(2, `CTS_ADDR_GTCNT, 32'h2);
        gate <= 1'b0;
        repeat (4) @(posedge clk);
        gate <= 1'b1;
        burst(2, `CTS_ADDR_GTCNT, 32'h2);
        acc(1'b1, `CTS_ADDR_MAIN, 32'h81);
        force_run <= 1'b1;
        burst(4, `CTS_ADDR_FTCNT, 32'h14);
        results;
    end
endmodule // cts_touch_counter_bench
